// ---- include/slot_switch_pkg.sv ----
package slot_switch_pkg;

	// Wishbone word offsets (byte addresses).
	localparam logic [3:0] ADDR_OFS = 4'h0;
	localparam logic [3:0] DATA_OFS = 4'h4;
	localparam logic [3:0] CMD_OFS = 4'h8;
	localparam logic [3:0] SUBSEL_OFS = 4'hC;

	localparam logic [7:0] SUBSEL_RESET = 8'h00;
	localparam logic [7:0] REG_RESET = 8'h00;

	// Command codes written to the memory access command register.
	localparam logic [7:0] CMD_WR_POINTER = 8'h48;
	localparam logic [7:0] CMD_RD_POINTER = 8'hC8;
	localparam logic [7:0] CMD_RD_CODE = 8'hF0;
	localparam logic [7:0] CMD_WR_TRISTATE = 8'h60;
	localparam logic [7:0] CMD_RD_TRISTATE = 8'hE0;
	localparam logic [3:0] CMD_SWITCH_HI = 4'h7;

	// Switch codes.
	localparam logic [3:0] CODE_UNASSIGNED = 4'h0;
	localparam logic [3:0] CODE_FULL = 4'h1;
	localparam logic [3:0] CODE_RESET = 4'h0;
	localparam logic [3:0] TRI_RESET = 4'h0;

	// Two-bit positions per configurable port in the subslot select register.
	localparam int SUBSEL_FIELD_W = 2;

	typedef enum logic [1:0] {
		OP_IDLE,
		OP_EXEC,
		OP_DONE
	} op_state_t;

	// One control memory entry.
	typedef struct packed {
		logic [3:0] code;
		logic [7:0] pointer;
	} cm_entry_t;

	// Command handed from the register file into the command FIFO.
	typedef struct packed {
		logic [7:0] command;
		logic [7:0] address;
		logic [7:0] data;
	} mem_op_t;

	localparam int MEM_OP_W = 24;

endpackage

// ---- logic/slot_switch_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module slot_switch_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] store_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0] count_q;
	logic push;
	logic pop;

	assign in_ready = count_q != (AW+1)'(DEPTH);
	assign out_valid = count_q != '0;
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = store_q[rd_q];

	always_ff @(posedge sys_clk) begin
		if (push) begin
			store_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
			count_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
			end
			count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ---- logic/tdm_slot_switch_control.sv ----
`timescale 1ns/1ns
`default_nettype none
// Function
// - The control memory has one entry per configurable slot, selected by the memory access address register.
// - Each entry's data field is a pointer to the PCM slot, loaded from the memory access data register.
// - Each entry has a 4-bit code and only codes with a zero top bit mark the slot as switched.
// - One downstream PCM slot may feed many configurable slots, but entries are indexed only by configurable slot.
// - Several full-rate upstream slots on one PCM slot simply overwrite each other in the data memory.
// - Command 71 hex writes the pointer and the full-slot code into the addressed entry.
// - Command 48 hex writes only the pointer and keeps the existing code.
// - Command 60 hex writes the low data nibble into the PCM slot's tristate field, 1 meaning driven.
// - The same command with nibble 0000 puts all bit pairs of that PCM slot at high impedance.
// - Command 70 hex stores code 0000 which marks the slot unassigned, whatever the data.
// - Subchannel codes restrict a slot pointer to 4 or 2 bits and select the PCM subslot position.
// - The subslot position inside a configurable slot is fixed per port by the subslot select register.
// - Each configurable slot carries at most one subslot, while a PCM slot may hold several.
// - The subslot select register is 8-bit read/write, reset zero, with pairs 7:6 to 1:0 for ports 3 to 0.
// - Command C8 hex reads the pointer and F0 hex reads the code into the data register low bits.
// - Bit 7 of a slot is the first serial bit and the most significant bus data bit.
module tdm_slot_switch_control
	import slot_switch_pkg::*;
#(
	parameter int SLOTS = 256,
	parameter int FIFO_DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] cfi_slot_index,
	output logic [7:0] cfi_pointer,
	output logic [3:0] cfi_code,
	output logic cfi_switched,
	output logic [7:0] cfi_bit_mask,
	output logic [7:0] pcm_bit_mask,
	input wire logic [7:0] pcm_slot_index,
	output logic [7:0] pcm_drive_en,
	output logic busy
);
	localparam int IW = $clog2(SLOTS);

	cm_entry_t control_memory_q [SLOTS];
	logic [3:0] tristate_q [SLOTS];
	logic [7:0] memory_access_address_q;
	logic [7:0] memory_access_data_q;
	logic [7:0] memory_access_command_q;
	logic [7:0] cfi_subslot_select_q;
	logic ack_q;
	op_state_t state_q;
	logic req;
	logic cmd_push;
	logic cmd_ready;
	logic op_valid;
	logic op_take;
	mem_op_t op_in;
	mem_op_t op_cur;
	logic [31:0] rd_word;
	logic data_wr_hw;
	logic [7:0] data_hw_d;

	// Maps a switch code to the PCM bits it carries; bit 7 is the first bit on the line.
	function automatic logic [7:0] code_mask(input logic [3:0] code);
		logic [7:0] m;
		m = 8'h00;
		unique case (code)
			4'h1: m = 8'hFF;
			4'h3: m = 8'hF0;
			4'h2: m = 8'h0F;
			4'h7: m = 8'hC0;
			4'h6: m = 8'h30;
			4'h5: m = 8'h0C;
			4'h4: m = 8'h03;
			default: m = 8'h00;
		endcase
		return m;
	endfunction

	// Configurable-side position: the port's select pair and the code's width decide it.
	function automatic logic [7:0] cfi_mask(input logic [3:0] code, input logic [1:0] sel);
		logic [7:0] m;
		logic [7:0] pm;
		pm = code_mask(code);
		m = 8'h00;
		if (pm == 8'hFF) begin
			m = 8'hFF;
		end else if (pm == 8'hF0 || pm == 8'h0F) begin
			m = sel[1] ? 8'hF0 : 8'h0F;
		end else if (pm != 8'h00) begin
			unique case (sel)
				2'b00: m = 8'h03;
				2'b01: m = 8'h30;
				2'b10: m = 8'h0C;
				2'b11: m = 8'h03;
			endcase
		end
		return m;
	endfunction

	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wb_ack_o = ack_q;
	// A command write is only acknowledged once the FIFO has room, so software stalls instead of losing it.
	assign cmd_push = req && wb_we_i && wb_adr_i == CMD_OFS && wb_sel_i[0];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req && (!cmd_push || cmd_ready);
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			memory_access_address_q <= REG_RESET;
			memory_access_command_q <= REG_RESET;
			cfi_subslot_select_q <= SUBSEL_RESET;
		end else if (req && wb_we_i && wb_sel_i[0] && (!cmd_push || cmd_ready)) begin
			unique case (wb_adr_i)
				ADDR_OFS: memory_access_address_q <= wb_dat_i[7:0];
				CMD_OFS: memory_access_command_q <= wb_dat_i[7:0];
				SUBSEL_OFS: cfi_subslot_select_q <= wb_dat_i[7:0];
				default: ;
			endcase
		end
	end

	// Read-back results win over a software write landing in the same cycle.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			memory_access_data_q <= REG_RESET;
		end else if (data_wr_hw) begin
			memory_access_data_q <= data_hw_d;
		end else if (req && wb_we_i && wb_sel_i[0] && wb_adr_i == DATA_OFS) begin
			memory_access_data_q <= wb_dat_i[7:0];
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (wb_adr_i)
			ADDR_OFS: rd_word[7:0] = memory_access_address_q;
			DATA_OFS: rd_word[7:0] = memory_access_data_q;
			CMD_OFS: rd_word[7:0] = memory_access_command_q;
			SUBSEL_OFS: rd_word[7:0] = cfi_subslot_select_q;
			default: rd_word = 32'h0000_0000;
		endcase
		rd_word[8] = busy;
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= rd_word;
		end
	end

	assign op_in = '{command: wb_dat_i[7:0], address: memory_access_address_q, data: memory_access_data_q};

	slot_switch_fifo #(
		.WIDTH(MEM_OP_W),
		.DEPTH(FIFO_DEPTH)
	) cmd_fifo (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.in_valid(cmd_push),
		.in_ready(cmd_ready),
		.in_data(op_in),
		.out_valid(op_valid),
		.out_ready(op_take),
		.out_data(op_cur)
	);

	assign op_take = state_q == OP_IDLE && op_valid;
	assign busy = op_valid || state_q != OP_IDLE;

	mem_op_t exec_q;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_q <= OP_IDLE;
			exec_q <= '0;
		end else begin
			unique case (state_q)
				OP_IDLE: if (op_take) begin
					state_q <= OP_EXEC;
					exec_q <= op_cur;
				end
				OP_EXEC: state_q <= OP_DONE;
				OP_DONE: state_q <= OP_IDLE;
			endcase
		end
	end

	logic [IW-1:0] ex_idx;
	assign ex_idx = IW'(exec_q.address);
	assign data_wr_hw = state_q == OP_EXEC && (exec_q.command == CMD_RD_POINTER ||
		exec_q.command == CMD_RD_CODE || exec_q.command == CMD_RD_TRISTATE);

	always_comb begin
		data_hw_d = 8'h00;
		if (exec_q.command == CMD_RD_POINTER) begin
			data_hw_d = control_memory_q[ex_idx].pointer;
		end else if (exec_q.command == CMD_RD_CODE) begin
			data_hw_d = {4'h0, control_memory_q[ex_idx].code};
		end else begin
			data_hw_d = {4'h0, tristate_q[ex_idx]};
		end
	end

	// Entries are indexed by configurable slot only, so each holds one pointer and one subslot.
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				control_memory_q[i] <= '{code: CODE_RESET, pointer: 8'h00};
			end
		end else if (state_q == OP_EXEC) begin
			if (exec_q.command[7:4] == CMD_SWITCH_HI) begin
				control_memory_q[ex_idx].code <= exec_q.command[3:0];
				if (exec_q.command[3:0] != CODE_UNASSIGNED) begin
					control_memory_q[ex_idx].pointer <= exec_q.data;
				end
			end else if (exec_q.command == CMD_WR_POINTER) begin
				control_memory_q[ex_idx].pointer <= exec_q.data;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				tristate_q[i] <= TRI_RESET;
			end
		end else if (state_q == OP_EXEC && exec_q.command == CMD_WR_TRISTATE) begin
			tristate_q[ex_idx] <= exec_q.data[3:0];
		end
	end

	// Switching view for the serial engine, registered so data outputs come from flops.
	logic [IW-1:0] cfi_idx;
	logic [1:0] port_sel;
	cm_entry_t cfi_ent;
	logic [3:0] pcm_tri;
	assign cfi_idx = IW'(cfi_slot_index);
	assign cfi_ent = control_memory_q[cfi_idx];
	// Port number sits in the low address bits; each port's pair is taken from the select register.
	assign port_sel = cfi_subslot_select_q[SUBSEL_FIELD_W*cfi_slot_index[1:0] +: SUBSEL_FIELD_W];
	assign pcm_tri = tristate_q[IW'(pcm_slot_index)];

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cfi_pointer <= 8'h00;
			cfi_code <= CODE_RESET;
			cfi_switched <= 1'b0;
			cfi_bit_mask <= 8'h00;
			pcm_bit_mask <= 8'h00;
			pcm_drive_en <= 8'h00;
		end else begin
			cfi_pointer <= cfi_ent.pointer;
			cfi_code <= cfi_ent.code;
			cfi_switched <= !cfi_ent.code[3] && cfi_ent.code != CODE_UNASSIGNED;
			cfi_bit_mask <= cfi_ent.code[3] ? 8'h00 : cfi_mask(cfi_ent.code, port_sel);
			pcm_bit_mask <= cfi_ent.code[3] ? 8'h00 : code_mask(cfi_ent.code);
			// Each tristate bit covers one bit pair, bit 3 the first pair on the line.
			pcm_drive_en <= {{2{pcm_tri[3]}}, {2{pcm_tri[2]}}, {2{pcm_tri[1]}}, {2{pcm_tri[0]}}};
		end
	end

	property ack_one_cycle;
		@(posedge sys_clk) disable iff (sys_rst) wb_ack_o |=> !wb_ack_o;
	endproperty
	ack_drops_a: assert property (ack_one_cycle) else $error("ack held two cycles");

	sequence op_start;
		state_q == OP_IDLE && op_valid;
	endsequence
	op_runs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_start |=> state_q == OP_EXEC ##1 state_q == OP_DONE) else $error("operation not run");

	full_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command == 8'h71 |=>
		control_memory_q[$past(ex_idx)].code == CODE_FULL &&
		control_memory_q[$past(ex_idx)].pointer == $past(exec_q.data)) else $error("full write wrong");

	ptr_only_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command == CMD_WR_POINTER |=>
		control_memory_q[$past(ex_idx)].code == $past(control_memory_q[ex_idx].code)) else $error("code changed");

	cancel_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command == 8'h70 |=>
		control_memory_q[$past(ex_idx)].code == CODE_UNASSIGNED) else $error("cancel failed");

	tristate_set_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command == CMD_WR_TRISTATE |=>
		tristate_q[$past(ex_idx)] == $past(exec_q.data[3:0])) else $error("tristate write wrong");

	tristate_off_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pcm_tri == 4'h0 |=> pcm_drive_en == 8'h00) else $error("driver not off");

	switched_flag_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cfi_switched |-> !cfi_code[3] && cfi_code != 4'h0) else $error("bad switched flag");

	read_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command == CMD_RD_POINTER |=>
		memory_access_data_q == $past(control_memory_q[ex_idx].pointer)) else $error("readback wrong");

	one_subslot_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		$countones(cfi_bit_mask) == $countones(pcm_bit_mask)) else $error("width mismatch");

	// The executing step of one queued command.
	sequence exec_cmd(logic [7:0] c);
		state_q == OP_EXEC && exec_q.command == c;
	endsequence

	// A bus request that the slave has not yet answered.
	sequence bus_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence

	rd_code_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		exec_cmd(CMD_RD_CODE) |=> memory_access_data_q == {4'h0, $past(control_memory_q[ex_idx].code)})
		else $error("code readback wrong");

	rd_tri_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		exec_cmd(CMD_RD_TRISTATE) |=> memory_access_data_q == {4'h0, $past(tristate_q[ex_idx])})
		else $error("tristate readback wrong");

	ptr_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		exec_cmd(CMD_WR_POINTER) |=> control_memory_q[$past(ex_idx)].pointer == $past(exec_q.data))
		else $error("pointer not written");

	cancel_ptr_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		exec_cmd(8'h70) |=> control_memory_q[$past(ex_idx)].pointer == $past(control_memory_q[ex_idx].pointer))
		else $error("cancel touched pointer");

	sub_write_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		state_q == OP_EXEC && exec_q.command[7:4] == CMD_SWITCH_HI && exec_q.command[3:0] != CODE_UNASSIGNED |=>
		control_memory_q[$past(ex_idx)].pointer == $past(exec_q.data) &&
		control_memory_q[$past(ex_idx)].code == $past(exec_q.command[3:0])) else $error("switch write wrong");

	full_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		cfi_code == CODE_FULL |-> cfi_bit_mask == 8'hFF && pcm_bit_mask == 8'hFF)
		else $error("full slot mask wrong");

	unswitched_mask_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!cfi_switched |-> cfi_bit_mask == 8'h00 && pcm_bit_mask == 8'h00)
		else $error("unswitched slot carries bits");

	drive_pairs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		pcm_drive_en[7] == pcm_drive_en[6] && pcm_drive_en[5] == pcm_drive_en[4] &&
		pcm_drive_en[3] == pcm_drive_en[2] && pcm_drive_en[1] == pcm_drive_en[0]) else $error("pair split");

	ack_after_req_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
		else $error("ack without request");

	cmd_stall_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_req and cmd_push && !cmd_ready |=> !wb_ack_o)
		else $error("full queue acked");

	busy_pending_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		op_valid |-> busy)
		else $error("busy low with work queued");

	subsel_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		!(req && wb_we_i && wb_adr_i == SUBSEL_OFS && wb_sel_i[0]) |=> $stable(cfi_subslot_select_q))
		else $error("subslot select changed");

	subsel_read_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		bus_req and !wb_we_i && wb_adr_i == SUBSEL_OFS |=> wb_dat_o[7:0] == $past(cfi_subslot_select_q))
		else $error("subslot select read wrong");
endmodule
`default_nettype wire

// ---- testbench/highway_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// Stands in for the serial highways, which present one configurable and one PCM slot index per slot step.
module highway_model (
	input wire logic sys_clk,
	input wire logic [7:0] cfi_pick,
	input wire logic [7:0] pcm_pick,
	output logic [7:0] cfi_slot_index = 8'h00,
	output logic [7:0] pcm_slot_index = 8'h00
);
	always @(posedge sys_clk) begin
		cfi_slot_index <= cfi_pick;
		pcm_slot_index <= pcm_pick;
	end
endmodule
`default_nettype wire

// ---- testbench/tdm_slot_switch_control_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tdm_slot_switch_control_test
	import slot_switch_pkg::*;
();
	logic sys_clk, sys_rst, cyc, stb, we, ack, busy, sw;
	logic [3:0] adr, sel, ccode;
	logic [31:0] wdat, rdat;
	logic [7:0] cpick, ppick, cidx, pidx, cptr, cmsk, pmsk, den;
	int num_errors = 0;
	int n_compared = 0;
	int m_ptr[256], m_code[256], m_tri[256];
	int m_sel;

	tdm_slot_switch_control #(.SLOTS(256), .FIFO_DEPTH(16)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .cfi_slot_index(cidx), .cfi_pointer(cptr), .cfi_code(ccode),
		.cfi_switched(sw), .cfi_bit_mask(cmsk), .pcm_bit_mask(pmsk), .pcm_slot_index(pidx),
		.pcm_drive_en(den), .busy(busy));
	highway_model hw (.sys_clk(sys_clk), .cfi_pick(cpick), .pcm_pick(ppick), .cfi_slot_index(cidx),
		.pcm_slot_index(pidx));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	task automatic stop_test();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task automatic wb(input logic [3:0] a, input logic w, input logic [7:0] d, output logic [31:0] q);
		int t;
		@(posedge sys_clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		t = 0;
		do begin
			@(posedge sys_clk);
			t++;
		end while (ack !== 1'b1 && t < 300);
		if (t >= 300) num_errors++;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic op(input int a, input int d, input logic [7:0] c);
		logic [31:0] q;
		wb(ADDR_OFS, 1'b1, a[7:0], q);
		wb(DATA_OFS, 1'b1, d[7:0], q);
		wb(CMD_OFS, 1'b1, c, q);
		if (c[7:4] == CMD_SWITCH_HI) begin
			m_code[a] = c[3:0];
			if (c[3:0] != 4'h0) m_ptr[a] = d;
		end else if (c == CMD_WR_POINTER) begin
			m_ptr[a] = d;
		end else if (c == CMD_WR_TRISTATE) begin
			m_tri[a] = d % 16;
		end
	endtask

	task automatic settle();
		int t;
		t = 0;
		repeat (2) @(posedge sys_clk);
		while (busy !== 1'b0 && t < 300) begin
			@(posedge sys_clk);
			t++;
		end
		if (t >= 300) num_errors++;
	endtask

	function automatic logic [7:0] pm(int c);
		case (c)
			1: return 8'hFF;
			2: return 8'h0F;
			3: return 8'hF0;
			4: return 8'h03;
			5: return 8'h0C;
			6: return 8'h30;
			default: return 8'hC0;
		endcase
	endfunction

	// Configurable-side position comes from the port's select pair, not from the code.
	function automatic logic [7:0] cm(int c, int pr);
		if (c == 1) return 8'hFF;
		if (c < 4) return pr[1] ? 8'hF0 : 8'h0F;
		case (pr)
			1: return 8'h30;
			2: return 8'h0C;
			default: return 8'h03;
		endcase
	endfunction

	function automatic logic [7:0] dx(int n);
		logic [7:0] e;
		for (int i = 0; i < 4; i++) e[2*i+:2] = {2{n[i]}};
		return e;
	endfunction

	task automatic look(input int s);
		int c;
		c = m_code[s];
		@(posedge sys_clk);
		cpick <= s[7:0];
		ppick <= s[7:0];
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK("pointer", m_ptr[s], cptr)
		`CHK("code", c, ccode)
		`CHK("switched", (c != 0 && c < 8), sw)
		`CHK("drive", dx(m_tri[s]), den)
		if (c > 0 && c < 8) begin
			`CHK("cfi mask", cm(c, (m_sel >> (2 * (s % 4))) % 4), cmsk)
			`CHK("pcm mask", pm(c), pmsk)
		end
	endtask

	task automatic rb(input int s, input logic [7:0] c, input int e);
		logic [31:0] q;
		op(s, 0, c);
		settle();
		wb(DATA_OFS, 1'b0, 8'h00, q);
		`CHK("readback", e, (c == CMD_RD_POINTER) ? q[7:0] : {4'h0, q[3:0]})
		`CHK("busy", 1'b0, q[8])
	endtask

	initial begin
		logic [31:0] q;
		int s, nib[4];
		sys_rst = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		sel = 4'hF;
		wdat = 32'h00000000;
		cpick = 8'h00;
		ppick = 8'h00;
		for (int i = 0; i < 256; i++) begin
			m_ptr[i] = 0;
			m_code[i] = 0;
			m_tri[i] = 0;
		end
		m_sel = 0;
		void'($urandom(61));
		repeat (3) @(posedge sys_clk);
		sys_rst <= 1'b0;
		wb(SUBSEL_OFS, 1'b0, 8'h00, q);
		`CHK("subsel reset", SUBSEL_RESET, q[7:0])
		wb(4'h2, 1'b0, 8'h00, q);
		`CHK("unmapped", 32'h00000000, q)
		look($urandom % 256);
		m_sel = $urandom % 256;
		wb(SUBSEL_OFS, 1'b1, m_sel[7:0], q);
		wb(SUBSEL_OFS, 1'b0, 8'h00, q);
		`CHK("subsel", m_sel, q[7:0])
		// A write without byte lane 0 must leave the register alone.
		sel <= 4'hE;
		wb(SUBSEL_OFS, 1'b1, ~m_sel[7:0], q);
		sel <= 4'hF;
		wb(SUBSEL_OFS, 1'b0, 8'h00, q);
		`CHK("subsel lane", m_sel, q[7:0])
		for (int c = 1; c < 9; c++) begin
			s = $urandom % 256;
			op(s, $urandom % 256, {CMD_SWITCH_HI, c[3:0]});
			settle();
			look(s);
			rb(s, CMD_RD_POINTER, m_ptr[s]);
			rb(s, CMD_RD_CODE, m_code[s]);
		end
		s = 8'h40;
		op(s, 8'h12, {CMD_SWITCH_HI, CODE_FULL});
		op(s, 8'h9A, CMD_WR_POINTER);
		op(s ^ 1, 8'h9A, {CMD_SWITCH_HI, CODE_FULL});
		settle();
		look(s);
		look(s ^ 1);
		op(s, $urandom % 256, {CMD_SWITCH_HI, CODE_UNASSIGNED});
		settle();
		look(s);
		nib = '{15, 0, 5, 0};
		nib[3] = $urandom % 16;
		foreach (nib[i]) begin
			s = $urandom % 256;
			op(s, nib[i], CMD_WR_TRISTATE);
			settle();
			look(s);
			rb(s, CMD_RD_TRISTATE, m_tri[s]);
		end
		// Commands follow each other with no settle between them; each leaves the queue before the next command write arrives.
		for (int k = 0; k < 20; k++) op(k * 11, $urandom % 256, {CMD_SWITCH_HI, CODE_FULL});
		settle();
		for (int k = 0; k < 20; k++) look(k * 11);
		stop_test();
	end

	initial begin
		repeat (30000) @(posedge sys_clk);
		num_errors++;
		stop_test();
	end
endmodule
`default_nettype wire
